// >>> include/dwsc_cfg.svh
// Purpose: Bit positions, widths and reset values for the disc write setup block
// Assumes: Included by the package, the write setup module and the bench
// Notes: Definitions only
`ifndef DWSC_CFG_SVH
`define DWSC_CFG_SVH

// Data path widths
`define DWSC_WORD_W 16
`define DWSC_SECTOR_W 7
`define DWSC_TRACK_W 7
`define DWSC_WCOUNT_W 6
`define DWSC_BCOUNT_W 4

// Status word layout
`define DWSC_ST_PHASE 15
`define DWSC_ST_NEXT_HI 14
`define DWSC_ST_NEXT_LO 8
`define DWSC_ST_READY 7
`define DWSC_ST_MATCH 5
`define DWSC_ST_ABORT 3
`define DWSC_ST_PARERR 1
`define DWSC_ST_BUSY 0

// Command word layout
`define DWSC_CW_DIR 15
`define DWSC_CW_TRK_HI 13
`define DWSC_CW_TRK_LO 7
`define DWSC_CW_SEC_HI 6
`define DWSC_CW_SEC_LO 0

// Power-up values and the sector counter step
`define DWSC_RST_WORD 16'h0000
`define DWSC_RST_SECTOR 7'h00
`define DWSC_RST_WCOUNT 6'h00
`define DWSC_RST_BCOUNT 4'h0
`define DWSC_SECTOR_STEP 7'h01

`endif

// >>> include/dwsc_pkg.sv
// Purpose: Shared types of the disc write setup block
// Assumes: Constants come from the configuration header
// Notes: Types only
`include "dwsc_cfg.svh"
package dwsc_pkg;
  // Sector number as held by the counter and the address register
  typedef logic [`DWSC_SECTOR_W-1:0] dwsc_sector_t;
  // Transfer direction held by the direction flip-flop
  typedef enum logic {
    DWSC_OP_READ = 1'b0,
    DWSC_OP_WRITE = 1'b1
  } dwsc_op_e;
endpackage

// >>> hw/dwsc_pulse_sync.sv
// Purpose: Bring an active-low disc pulse into the clock domain and mark its edges
// Assumes: Pulse is wider than two clock periods
// Notes: Leading edge is the fall of the low-true input
`timescale 1ns/100ps
`default_nettype none
module dwsc_pulse_sync
  import dwsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pulseN,
  output logic leadEdge,
  output logic trailEdge
);
  logic meta; // First stage, read only by the second stage
  logic stable; // Second stage, safe to use
  logic last; // Delayed copy for edge detection

  // Two-stage synchroniser plus history; idle level is high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta <= 1'b1;
      stable <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pulseN;
      stable <= meta;
      last <= stable;
    end
  end

  // Edge marks last one cycle each
  assign leadEdge = last & ~stable;
  assign trailEdge = ~last & stable;
endmodule
`default_nettype wire

// >>> hw/dwsc_sector_tracker.sv
// Purpose: Sector phase divider and next-sector counter
// Assumes: Edge pulses come from the synchronisers, one cycle each
// Notes: Counter counts only once track origin has been seen
`timescale 1ns/100ps
`default_nettype none
module dwsc_sector_tracker
  import dwsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sectorLead,
  input wire logic sectorTrail,
  input wire logic originLead,
  output logic sectorPhaseFf,
  output dwsc_pkg::dwsc_sector_t nextSector,
  output logic firstPulseLead,
  output logic secondPulseLead
);
  logic originSeen; // Phase is meaningless before the first origin

  // Divide-by-two phase and counter; origin realigns both
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sectorPhaseFf <= 1'b0;
      nextSector <= `DWSC_RST_SECTOR;
      originSeen <= 1'b0;
    end else if (originLead) begin
      sectorPhaseFf <= 1'b0;
      nextSector <= `DWSC_RST_SECTOR;
      originSeen <= 1'b1;
    end else if (originSeen && sectorTrail) begin
      sectorPhaseFf <= ~sectorPhaseFf;
      // Advance only as the phase returns to reset
      if (sectorPhaseFf) begin
        nextSector <= nextSector + `DWSC_SECTOR_STEP;
      end
    end
  end

  // First and second pulse of a sector told apart by the phase
  assign firstPulseLead = sectorLead & ~sectorPhaseFf & originSeen;
  assign secondPulseLead = sectorLead & sectorPhaseFf;

  property p_advance_on_fall;
    @(posedge sys_clk) disable iff (sys_rst)
    sectorTrail && sectorPhaseFf && !originLead |=>
      !sectorPhaseFf && nextSector == $past(nextSector) + `DWSC_SECTOR_STEP;
  endproperty
  a_advance_on_fall: assert property (p_advance_on_fall)
    else $error("sector counter did not advance with phase reset");

  property p_origin_clears;
    @(posedge sys_clk) disable iff (sys_rst)
    originLead |=> nextSector == `DWSC_RST_SECTOR && !sectorPhaseFf;
  endproperty
  a_origin_clears: assert property (p_origin_clears)
    else $error("track origin did not clear sector counter");

  property p_first_trail_sets;
    @(posedge sys_clk) disable iff (sys_rst)
    originSeen && !sectorPhaseFf && sectorTrail && !originLead |=> sectorPhaseFf;
  endproperty
  a_first_trail_sets: assert property (p_first_trail_sets)
    else $error("first sector pulse trail did not set phase");
endmodule
`default_nettype wire

// >>> hw/dwsc_write_setup.sv
// Purpose: Command and data card control logic for starting a disc transfer
// Assumes: Bus timing inputs are synchronous; timeT4 is high for the T4 cycle
// Notes: Serial writing, reading and sector-end termination live elsewhere
// Functional notes
// - Status bits 14-8 show next sector
// - Phase set warns; counter advances on reset
// - Status bit 15 shows sector phase
// - Late start waits with control held set, run clear
// - Busy bit is control OR run
// - Phase setup; second pulse clears, sets strobes
// - Defined power-up state of all flip-flops
// - Status read changes no flip-flop
// - Command output clears run, control, match
// - Command loads track 13-7, sector 6-0
// - Command bit 15 selects write direction
// - Command fields captured during T4
// - Start sets flag, control; clears shift, parity
// - Start clears parity error and abort
// - Flag set drives service request
// - DMA word loads input register; clear-flag
// - Control holds set while awaiting sector
// - Counter steps per sector, clears at origin
// - Abort latch readable as status bit 3
`timescale 1ns/100ps
`default_nettype none
`include "dwsc_cfg.svh"
module dwsc_write_setup
  import dwsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmdCardSelect,
  input wire logic dataCardSelect,
  input wire logic timeT4,
  input wire logic gateEnable,
  input wire logic outputStrobe,
  input wire logic loadStatusInstruction,
  input wire logic setControlInstruction,
  input wire logic clearControlInstruction,
  input wire logic clearFlagSignal,
  input wire logic [`DWSC_WORD_W-1:0] outputBus,
  input wire logic sectorPulseN,
  input wire logic trackOriginPulseN,
  input wire logic discNotReady,
  output logic [`DWSC_WORD_W-1:0] inputBus,
  output logic serviceRequest,
  output dwsc_pkg::dwsc_op_e directionFf,
  output logic [`DWSC_TRACK_W-1:0] trackAddress,
  output dwsc_pkg::dwsc_sector_t sectorAddress,
  output logic [`DWSC_WORD_W-1:0] inputRegister,
  output logic [`DWSC_WORD_W-1:0] dataShift,
  output logic controlBit,
  output logic flag,
  output logic runFf,
  output logic sectorMatchFf,
  output logic abortLatch,
  output logic readParityFf,
  output logic readParityErrorFf,
  output logic endOfSectorFf,
  output logic wordStrobeFf,
  output logic wordActiveFf,
  output logic trackOriginLatch,
  output logic [`DWSC_WCOUNT_W-1:0] wordCount,
  output logic [`DWSC_BCOUNT_W-1:0] bitCount
);
  // Bus cycle addressed to a card, qualified by the gate and T4
  function automatic logic busCycle(input logic sel, input logic gate, input logic t4);
    busCycle = sel & gate & t4;
  endfunction

  logic sectorLead; // Leading edge of a sector pulse
  logic sectorTrail; // Trailing edge of a sector pulse
  logic originLead; // Leading edge of track origin
  logic sectorPhaseFf; // Set between the two pulses of a sector
  dwsc_sector_t nextSector; // One above the sector under the heads
  logic firstPulseLead; // First pulse of a sector begins
  logic secondPulseLead; // Second pulse of a sector begins
  logic cmdCycle; // Command card addressed this T4
  logic dataCycle; // Data card addressed this T4
  logic commandLoad; // Output instruction to command card
  logic startCycle; // Set-control to data card
  logic stopCycle; // Clear-control to data card
  logic dmaLoad; // DMA word into the input register
  logic dataClearFlag; // Clear-flag to data card
  logic cmdClearFlag; // Clear-flag to command card
  logic statusRead; // Status read from command card
  logic runStart; // Run about to set for the chosen sector
  logic next_flag; // Flag value for the next edge
  logic [`DWSC_WORD_W-1:0] statusWord; // Assembled status word

  // Disc pulses are asynchronous, so each passes a synchroniser
  dwsc_pulse_sync u_sector_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pulseN(sectorPulseN),
    .leadEdge(sectorLead),
    .trailEdge(sectorTrail)
  );

  dwsc_pulse_sync u_origin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pulseN(trackOriginPulseN),
    .leadEdge(originLead),
    .trailEdge()
  );

  // Phase divider and next-sector counter
  dwsc_sector_tracker u_tracker (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sectorLead(sectorLead),
    .sectorTrail(sectorTrail),
    .originLead(originLead),
    .sectorPhaseFf(sectorPhaseFf),
    .nextSector(nextSector),
    .firstPulseLead(firstPulseLead),
    .secondPulseLead(secondPulseLead)
  );

  // Decode of the timed bus signals; everything acts in T4
  assign cmdCycle = busCycle(cmdCardSelect, gateEnable, timeT4);
  assign dataCycle = busCycle(dataCardSelect, gateEnable, timeT4);
  assign commandLoad = cmdCycle & outputStrobe;
  assign startCycle = dataCycle & setControlInstruction;
  assign stopCycle = dataCycle & clearControlInstruction;
  assign dmaLoad = dataCycle & outputStrobe;
  assign dataClearFlag = dataCycle & clearFlagSignal;
  assign cmdClearFlag = cmdCycle & clearFlagSignal;
  assign statusRead = cmdCycle & loadStatusInstruction;
  // Second pulse of the matched sector starts the transfer
  assign runStart = secondPulseLead & sectorMatchFf & ~runFf & controlBit;

  // Status word assembly; reserved bits read zero
  always_comb begin
    statusWord = `DWSC_RST_WORD;
    statusWord[`DWSC_ST_PHASE] = sectorPhaseFf;
    statusWord[`DWSC_ST_NEXT_HI:`DWSC_ST_NEXT_LO] = nextSector;
    statusWord[`DWSC_ST_READY] = ~discNotReady;
    statusWord[`DWSC_ST_MATCH] = sectorMatchFf;
    statusWord[`DWSC_ST_ABORT] = abortLatch;
    statusWord[`DWSC_ST_PARERR] = readParityErrorFf;
    statusWord[`DWSC_ST_BUSY] = controlBit | runFf;
  end

  // Status drive, one cycle after the read; the read touches no state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      inputBus <= `DWSC_RST_WORD;
    end else if (statusRead) begin
      inputBus <= statusWord;
    end else begin
      // Idle bus reads as zero
      inputBus <= `DWSC_RST_WORD;
    end
  end

  // Command word capture: direction, track and sector
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      directionFf <= DWSC_OP_READ;
      trackAddress <= `DWSC_RST_SECTOR;
      sectorAddress <= `DWSC_RST_SECTOR;
    end else if (commandLoad) begin
      directionFf <= dwsc_op_e'(outputBus[`DWSC_CW_DIR]);
      // Track goes to the data card even though the command card is addressed
      trackAddress <= outputBus[`DWSC_CW_TRK_HI:`DWSC_CW_TRK_LO];
      sectorAddress <= outputBus[`DWSC_CW_SEC_HI:`DWSC_CW_SEC_LO];
    end
  end

  // Control bit: set by start, forced off by a new command or a stop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      controlBit <= 1'b0;
    end else if (commandLoad || stopCycle) begin
      controlBit <= 1'b0;
    end else if (startCycle) begin
      controlBit <= 1'b1;
    end
    // Otherwise held through the sector wait
  end

  // Flag: start and run start set it, clear-flag resets it; set wins
  always_comb begin
    next_flag = flag;
    if (startCycle || runStart) begin
      next_flag = 1'b1;
    end else if (dataClearFlag) begin
      next_flag = 1'b0;
    end
  end

  // Flag and its request share one next value so they never disagree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
      serviceRequest <= 1'b0;
    end else begin
      flag <= next_flag;
      serviceRequest <= next_flag;
    end
  end

  // Input register takes the DMA word
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      inputRegister <= `DWSC_RST_WORD;
    end else if (dmaLoad) begin
      inputRegister <= outputBus;
    end
  end

  // Shift register: cleared at start, first word moved in at run start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataShift <= `DWSC_RST_WORD;
    end else if (startCycle) begin
      dataShift <= `DWSC_RST_WORD;
    end else if (runStart) begin
      dataShift <= inputRegister;
    end
  end

  // Sector match follows the control bit and the ready line
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sectorMatchFf <= 1'b0;
    end else if (!controlBit || commandLoad || stopCycle || discNotReady) begin
      sectorMatchFf <= 1'b0;
    end else if (firstPulseLead && nextSector == sectorAddress) begin
      sectorMatchFf <= 1'b1;
    end
  end

  // Run: a late start simply waits for the sector to come round again
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      runFf <= 1'b0;
    end else if (commandLoad || !controlBit) begin
      runFf <= 1'b0;
    end else if (runStart) begin
      runFf <= 1'b1;
    end
  end

  // Abort latch: not-ready sets, start clears; set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      abortLatch <= 1'b1;
    end else if (discNotReady) begin
      abortLatch <= 1'b1;
    end else if (startCycle) begin
      abortLatch <= 1'b0;
    end
  end

  // Parity flip-flops only matter for reads, but start resets them anyway
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readParityFf <= 1'b1;
      readParityErrorFf <= 1'b0;
    end else if (startCycle) begin
      readParityFf <= 1'b0;
      readParityErrorFf <= 1'b0;
    end
  end

  // Track origin latch: origin sets, command clear-flag resets; set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trackOriginLatch <= 1'b1;
    end else if (originLead) begin
      trackOriginLatch <= 1'b1;
    end else if (cmdClearFlag) begin
      trackOriginLatch <= 1'b0;
    end
  end

  // Second sector pulse restarts word framing; counters idle here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      endOfSectorFf <= 1'b0;
      wordStrobeFf <= 1'b1;
      wordActiveFf <= 1'b1;
      wordCount <= `DWSC_RST_WCOUNT;
      bitCount <= `DWSC_RST_BCOUNT;
    end else if (secondPulseLead) begin
      endOfSectorFf <= 1'b0;
      wordStrobeFf <= 1'b1;
      wordActiveFf <= 1'b1;
      wordCount <= `DWSC_RST_WCOUNT;
      bitCount <= `DWSC_RST_BCOUNT;
    end
  end

  property p_status_next;
    @(posedge sys_clk) disable iff (sys_rst)
    statusRead |=> inputBus[`DWSC_ST_NEXT_HI:`DWSC_ST_NEXT_LO] == $past(nextSector);
  endproperty
  a_status_next: assert property (p_status_next)
    else $error("status did not show next sector");

  property p_status_phase;
    @(posedge sys_clk) disable iff (sys_rst)
    statusRead |=> inputBus[`DWSC_ST_PHASE] == $past(sectorPhaseFf);
  endproperty
  a_status_phase: assert property (p_status_phase)
    else $error("status bit 15 not sector phase");

  property p_status_busy;
    @(posedge sys_clk) disable iff (sys_rst)
    statusRead |=> inputBus[`DWSC_ST_BUSY] == ($past(controlBit) | $past(runFf));
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("busy bit not control or run");

  property p_status_abort;
    @(posedge sys_clk) disable iff (sys_rst)
    statusRead |=> inputBus[`DWSC_ST_ABORT] == $past(abortLatch);
  endproperty
  a_status_abort: assert property (p_status_abort)
    else $error("status bit 3 not abort latch");

  property p_read_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
    statusRead && !dataCycle && !originLead && !sectorLead && !sectorTrail && !discNotReady
      |=> $stable(controlBit) && $stable(flag) && $stable(runFf) && $stable(abortLatch);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("status read changed state");

  property p_command_stops;
    @(posedge sys_clk) disable iff (sys_rst)
    commandLoad |=> !controlBit && !runFf ##1 !sectorMatchFf;
  endproperty
  a_command_stops: assert property (p_command_stops)
    else $error("command did not stop operation");

  property p_command_fields;
    @(posedge sys_clk) disable iff (sys_rst)
    commandLoad |=> trackAddress == $past(outputBus[13:7])
      && sectorAddress == $past(outputBus[6:0])
      && directionFf == dwsc_op_e'($past(outputBus[15]));
  endproperty
  a_command_fields: assert property (p_command_fields)
    else $error("command word fields not captured");

  property p_start_effects;
    @(posedge sys_clk) disable iff (sys_rst)
    startCycle && !discNotReady |=> flag && controlBit && serviceRequest
      && dataShift == `DWSC_RST_WORD && !readParityFf && !readParityErrorFf && !abortLatch;
  endproperty
  a_start_effects: assert property (p_start_effects)
    else $error("start instruction effects missing");

  property p_dma_word;
    @(posedge sys_clk) disable iff (sys_rst)
    dmaLoad && dataClearFlag && !startCycle && !runStart
      |=> inputRegister == $past(outputBus) && !flag && !serviceRequest;
  endproperty
  a_dma_word: assert property (p_dma_word)
    else $error("DMA word not taken or flag kept");

  property p_control_holds;
    @(posedge sys_clk) disable iff (sys_rst)
    controlBit && !commandLoad && !stopCycle |=> controlBit;
  endproperty
  a_control_holds: assert property (p_control_holds)
    else $error("control bit dropped while waiting");

  property p_second_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
    secondPulseLead |=> wordStrobeFf && wordActiveFf && !endOfSectorFf
      && wordCount == `DWSC_RST_WCOUNT && bitCount == `DWSC_RST_BCOUNT;
  endproperty
  a_second_pulse: assert property (p_second_pulse)
    else $error("second sector pulse effects missing");

  property p_power_up;
    @(posedge sys_clk) sys_rst |=> abortLatch && wordStrobeFf && trackOriginLatch
      && readParityFf && !controlBit && !flag && !runFf && !sectorMatchFf;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up state wrong");

  c_start: cover property (@(posedge sys_clk) disable iff (sys_rst) startCycle);
  c_command: cover property (@(posedge sys_clk) disable iff (sys_rst) commandLoad);
  c_dma: cover property (@(posedge sys_clk) disable iff (sys_rst) dmaLoad && flag);
  c_run: cover property (@(posedge sys_clk) disable iff (sys_rst) runStart);
endmodule
`default_nettype wire

// >>> bench/dwsc_dma_model.sv
// Purpose: DMA channel model that answers service requests
// Assumes: Bench supplies the word and the answer delay
// Notes: One cycle line stands for select, gate, T4, strobe, clear-flag
`timescale 1ns/100ps
`default_nettype none
module dwsc_dma_model (
  input wire logic sys_clk,
  input wire logic enable,
  input wire logic serviceRequest,
  input wire logic [2:0] lat,
  input wire logic [15:0] word,
  output logic dmaCycle,
  output logic [15:0] dmaBus
);
  // Request loop, driven just after a rising edge
  initial begin
    dmaCycle = 1'b0;
    dmaBus = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (enable && serviceRequest) begin
        repeat (lat) @(posedge sys_clk);
        dmaCycle <= 1'b1; // Word load and clear-flag together
        dmaBus <= word;
        @(posedge sys_clk);
        dmaCycle <= 1'b0;
        dmaBus <= ~word; // Released bus must not look like a stale word
        @(posedge sys_clk); // Flag only falls after the taking edge
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/dwsc_write_setup_test.sv
// Purpose: Self-checking bench for the disc write setup block
// Assumes: Disc pulses last several clocks, sync latency about 3
// Notes: Every output is compared as one snapshot vector
`timescale 1ns/100ps
`default_nettype none
`include "dwsc_cfg.svh"
module dwsc_write_setup_test;
  logic sys_clk = 1'b0; // 50 MHz
  logic sys_rst = 1'b1;
  logic bCs, bDc, bSt, bLd, bSc, bCf, bOp; // Bench bus strobes
  logic [15:0] bBus;
  logic sectorN = 1'b1, originN = 1'b1, dmaOn = 1'b0;
  logic [2:0] lat = 3'h0; // Partner answer delay
  logic [15:0] dmaWord = 16'h0000;
  logic dmaCycle;
  logic [15:0] dmaBus, inputBus, inputRegister, dataShift;
  logic serviceRequest, controlBit, flag, runFf, sectorMatchFf, abortLatch;
  logic readParityFf, readParityErrorFf, endOfSectorFf, wordStrobeFf;
  logic wordActiveFf, trackOriginLatch;
  dwsc_pkg::dwsc_op_e directionFf;
  logic [6:0] trackAddress;
  dwsc_pkg::dwsc_sector_t sectorAddress;
  logic [`DWSC_WCOUNT_W-1:0] wordCount;
  logic [`DWSC_BCOUNT_W-1:0] bitCount;
  // Expected state
  logic eCb, eFlag, eRun, eMatch, eAbort, eRp, eTol, ePh, eDir;
  logic [6:0] eNext, eTrk, eSec;
  logic [15:0] eIr, eDs;
  logic [31:0] seed = 32'h0000_84f0;
  logic [75:0] expQ[$]; // Notes waiting for the monitor
  event look;
  int failCount = 0;
  int numChecks = 0;
  wire logic [75:0] obs;
  assign obs = {inputBus, inputRegister, dataShift, controlBit, flag, serviceRequest,
    runFf, sectorMatchFf, abortLatch, readParityFf, readParityErrorFf, endOfSectorFf,
    wordStrobeFf, wordActiveFf, trackOriginLatch, directionFf, trackAddress,
    sectorAddress, |{wordCount, bitCount}};

  always #10 sys_clk = ~sys_clk;

  dwsc_write_setup dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmdCardSelect(bCs),
    .dataCardSelect(bDc | dmaCycle), .timeT4(bOp | dmaCycle), .gateEnable(bOp | dmaCycle),
    .outputStrobe(bSt | dmaCycle), .loadStatusInstruction(bLd),
    .setControlInstruction(bSc), .clearControlInstruction(1'b0),
    .clearFlagSignal(bCf | dmaCycle), .outputBus(bOp ? bBus : dmaBus),
    .sectorPulseN(sectorN), .trackOriginPulseN(originN), .discNotReady(1'b0),
    .inputBus(inputBus), .serviceRequest(serviceRequest), .directionFf(directionFf),
    .trackAddress(trackAddress), .sectorAddress(sectorAddress),
    .inputRegister(inputRegister), .dataShift(dataShift), .controlBit(controlBit),
    .flag(flag), .runFf(runFf), .sectorMatchFf(sectorMatchFf), .abortLatch(abortLatch),
    .readParityFf(readParityFf), .readParityErrorFf(readParityErrorFf),
    .endOfSectorFf(endOfSectorFf), .wordStrobeFf(wordStrobeFf),
    .wordActiveFf(wordActiveFf), .trackOriginLatch(trackOriginLatch),
    .wordCount(wordCount), .bitCount(bitCount));

  dwsc_dma_model dma_u (.sys_clk(sys_clk), .enable(dmaOn), .serviceRequest(serviceRequest),
    .lat(lat), .word(dmaWord), .dmaCycle(dmaCycle), .dmaBus(dmaBus));

  // Shift register step for random words
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  // Status word built from the expected state; ready is always high here
  function automatic logic [15:0] st();
    return {ePh, eNext, 1'b1, 1'b0, eMatch, 1'b0, eAbort, 2'b00, eCb | eRun};
  endfunction

  task automatic check(input logic [75:0] seen, input logic [75:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Records a note and wakes the monitor
  task automatic note(input logic [15:0] b);
    expQ.push_back({b, eIr, eDs, eCb, eFlag, eFlag, eRun, eMatch, eAbort, eRp,
      3'b001, 1'b1, eTol, eDir, eTrk, eSec, 1'b0});
    ->look;
  endtask

  // Monitor: oldest note against the settled outputs
  always @(look) check(obs, expQ.pop_front());

  // One bus cycle, held through the taking edge
  task automatic op(input logic [5:0] c, input logic [15:0] w);
    @(negedge sys_clk);
    {bCs, bDc, bSt, bLd, bSc, bCf} = c;
    bOp = 1'b1;
    bBus = w;
    @(negedge sys_clk);
    {bCs, bDc, bSt, bLd, bSc, bCf} = 6'h00;
    bOp = 1'b0;
    bBus = ~w;
  endtask

  // Status read; word stands one cycle
  task automatic rd();
    op(6'b100100, 16'h0000);
    note(st());
  endtask

  // Command load, then one more cycle for the match clear
  task automatic cmd(input logic [15:0] w);
    op(6'b101000, w);
    eDir = w[15];
    eTrk = w[13:7];
    eSec = w[6:0];
    {eCb, eRun, eMatch} = 3'b000;
    @(negedge sys_clk);
    note(16'h0000);
  endtask

  // Low-true disc pulse, long enough for the synchronisers
  task automatic pulse(input logic org);
    @(negedge sys_clk);
    if (org) begin
      originN = 1'b0;
    end else begin
      sectorN = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    originN = 1'b1;
    sectorN = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #400_000;
    failCount++;
    stopTest();
  end

  // Main sequence
  initial begin
    {bCs, bDc, bSt, bLd, bSc, bCf, bOp} = 7'h00;
    bBus = 16'h0000;
    {eCb, eFlag, eRun, eMatch, ePh, eDir} = 6'h00;
    {eAbort, eRp, eTol} = 3'b111;
    {eNext, eTrk, eSec, eIr, eDs} = 53'h0;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    note(16'h0000);
    rd();
    rd();
    op(6'b100001, 16'h0000);
    eTol = 1'b0;
    note(16'h0000);
    pulse(1'b1);
    eTol = 1'b1;
    note(16'h0000);
    pulse(1'b0);
    ePh = 1'b1;
    rd();
    pulse(1'b0);
    ePh = 1'b0;
    eNext = 7'h01;
    rd();
    for (int i = 0; i < 3; i++) begin
      seed = lf(seed);
      cmd(seed[15:0]);
    end
    seed = lf(seed);
    dmaWord = seed[15:0];
    dmaOn = 1'b1; // Channel set up before the command
    seed = lf(seed);
    cmd({1'b1, seed[14:7], 7'h01}); // Write to the next sector
    op(6'b010010, 16'h0000);
    {eCb, eFlag, eRp, eAbort} = 4'b1100;
    eDs = 16'h0000;
    note(16'h0000);
    repeat (6) @(negedge sys_clk);
    eFlag = 1'b0;
    eIr = dmaWord;
    note(16'h0000);
    rd();
    seed = lf(seed);
    lat = 3'h5;
    dmaWord = seed[15:0];
    pulse(1'b0);
    eMatch = 1'b1;
    ePh = 1'b1;
    rd();
    pulse(1'b0);
    eRun = 1'b1;
    eDs = eIr;
    eIr = dmaWord;
    ePh = 1'b0;
    eNext = 7'h02;
    rd();
    cmd(16'h0005);
    rd();
    stopTest();
  end
endmodule
`default_nettype wire
